// *** common/lec_defines.svh ***
// Register indices, field positions, reset values and timing for the lookup engine
`ifndef LEC_DEFINES_SVH
`define LEC_DEFINES_SVH

// Register indices; byte address is four times the index
`define LEC_IDX_FLUSH_TRIG 10'h311
`define LEC_IDX_CTL_B 10'h312
`define LEC_IDX_AGE 10'h313
`define LEC_IDX_STATUS 10'h314
`define LEC_IDX_MASK 10'h315

// Flush trigger register fields
`define LEC_TRIG_TABLE 5
`define LEC_TRIG_MSTP 4

// Control B fields
`define LEC_CTL_RSVD 7
`define LEC_CTL_MC_TRAP 6
`define LEC_CTL_DYN_EVF 5
`define LEC_CTL_STA_EVF 4
`define LEC_CTL_SCOPE_HI 3
`define LEC_CTL_SCOPE_LO 2
`define LEC_CTL_PRIO_HI 1
`define LEC_CTL_PRIO_LO 0

// Status and mask fields
`define LEC_ST_LEARN_FAIL 2
`define LEC_ST_ALMOST_FULL 1
`define LEC_ST_WRITE_FAIL 0

// Reset values
`define LEC_RST_CTL_B 8'h00
`define LEC_RST_AGE 8'h4b
`define LEC_RST_STATUS 3'h0
`define LEC_RST_MASK 3'h7

// Timing: one aging second
`define LEC_SECOND_NS 1000000000
`define LEC_CLK_PERIOD_NS 20
`define LEC_CYCLES_PER_SECOND (`LEC_SECOND_NS / `LEC_CLK_PERIOD_NS)

`endif

// *** common/lec_pkg.sv ***
// Types shared by the lookup engine control block
package lec_pkg;

	typedef enum logic [1:0] {
		LEC_SCOPE_NONE = 2'h0,
		LEC_SCOPE_DYNAMIC = 2'h1,
		LEC_SCOPE_STATIC = 2'h2,
		LEC_SCOPE_BOTH = 2'h3
	} lec_scope_type;

	typedef enum logic [1:0] {
		LEC_PRIO_DA = 2'h0,
		LEC_PRIO_SA = 2'h1,
		LEC_PRIO_HIGHER = 2'h2,
		LEC_PRIO_LOWER = 2'h3
	} lec_prio_sel_type;

	typedef enum logic [1:0] {
		LEC_FL_IDLE = 2'b01,
		LEC_FL_BUSY = 2'b10
	} lec_flush_state_type;

endpackage

// *** design/lec_fwd_resolve.sv ***
// Forwarding port map and address priority resolution for one lookup
`timescale 1ns/1ps
module lec_fwd_resolve #(
	parameter int NUM_PORTS = 7,
	parameter int HOST_PORT = 6,
	parameter int PRIO_W = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Settings
	input wire logic mc_trap,
	input wire logic dyn_filter,
	input wire logic sta_filter,
	input wire lec_pkg::lec_prio_sel_type prio_sel,
	// Lookup result
	input wire logic lookup_valid,
	input wire logic hit_dynamic,
	input wire logic hit_static,
	input wire logic reserved_mcast,
	input wire logic double_tag_mode,
	input wire logic [NUM_PORTS-1:0] table_port_map,
	input wire logic [NUM_PORTS-1:0] vlan_port_map,
	input wire logic [PRIO_W-1:0] da_prio,
	input wire logic [PRIO_W-1:0] sa_prio,
	// Resolved result
	output logic fwd_valid_q,
	output logic [NUM_PORTS-1:0] fwd_port_map_q,
	output logic [PRIO_W-1:0] address_based_priority_q
);

	if (HOST_PORT < 0 || HOST_PORT >= NUM_PORTS) begin : g_chk_host
		$error("HOST_PORT out of range");
	end

	localparam logic [NUM_PORTS-1:0] HOST_MAP =
		NUM_PORTS'(1) << HOST_PORT;

	wire logic trap = mc_trap && double_tag_mode && reserved_mcast;
	wire logic filt = (hit_dynamic && dyn_filter) ||
		(hit_static && sta_filter);
	wire logic [NUM_PORTS-1:0] filtered = table_port_map & vlan_port_map;
	wire logic [NUM_PORTS-1:0] map_d = trap ? HOST_MAP :
		(filt ? filtered : table_port_map);
	wire logic da_higher = da_prio > sa_prio;
	logic [PRIO_W-1:0] prio_d;

	always_comb begin
		case (prio_sel)
			lec_pkg::LEC_PRIO_DA: prio_d = da_prio;
			lec_pkg::LEC_PRIO_SA: prio_d = sa_prio;
			lec_pkg::LEC_PRIO_HIGHER:
				prio_d = da_higher ? da_prio : sa_prio;
			lec_pkg::LEC_PRIO_LOWER:
				prio_d = da_higher ? sa_prio : da_prio;
			default: prio_d = da_prio;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_valid_q <= 1'b0;
			fwd_port_map_q <= '0;
			address_based_priority_q <= '0;
		end else begin
			fwd_valid_q <= lookup_valid;
			if (lookup_valid) begin
				fwd_port_map_q <= map_d;
				address_based_priority_q <= prio_d;
			end
		end
	end

endmodule

// *** design/lec_ctrl_status.sv ***
// Lookup engine control and status registers behind an APB slave
`timescale 1ns/1ps
`include "lec_defines.svh"

// How it works
// - Trap bit with double tagging sends reserved multicast to host port only.
// - Dynamic filter on: dynamic hit forwards to table map AND VLAN map.
// - Static filter on: static hit forwards to table map AND VLAN map.
// - Flush scope 01 dynamic only, 10 static only, 11 both.
// - Scope 00 means no flush, and also reports that a flush finished.
// - Scope governs both whole-table and spanning-tree matched-entry flushes.
// - Priority selector 00 uses DA lookup, 01 uses SA lookup.
// - Priority selector 10 uses the greater of DA and SA priority.
// - Priority selector 11 uses the smaller of DA and SA priority.
// - Aging time equals age period seconds times entry age count; resets 0x4b.
// - Learn failure latched when every bucket entry is static.
// - Almost full latched when static write lands in bucket with 2 or 3.
// - Write failure latched when static write finds bucket full.
// - Status bits reset zero, stay latched, cleared only by software write.
// - Summary output is OR of the three status bits.
// - Per-bit mask, one disables, zero enables; masks reset to one.
// - Table flush trigger bounded by scope, self-clears; scope 10 or 11 includes the static table.
module lec_ctrl_status #(
	parameter int NUM_PORTS = 7,
	parameter int HOST_PORT = 6,
	parameter int PRIO_W = 3,
	parameter int CYCLES_PER_SECOND = `LEC_CYCLES_PER_SECOND
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lookup result from the datapath
	input wire logic lookup_valid,
	input wire logic hit_dynamic,
	input wire logic hit_static,
	input wire logic reserved_mcast,
	input wire logic double_tag_mode,
	input wire logic [NUM_PORTS-1:0] table_port_map,
	input wire logic [NUM_PORTS-1:0] vlan_port_map,
	input wire logic [PRIO_W-1:0] da_prio,
	input wire logic [PRIO_W-1:0] sa_prio,
	// Resolved forwarding result
	output logic fwd_valid,
	output logic [NUM_PORTS-1:0] fwd_port_map,
	output logic [PRIO_W-1:0] address_based_priority,
	// Table events
	input wire logic learn_attempt,
	input wire logic bucket_all_static,
	input wire logic static_write,
	input wire logic [2:0] bucket_fill,
	// Flush engine
	output logic flush_table_start,
	output logic flush_mstp_start,
	output logic [1:0] flush_scope,
	input wire logic flush_done,
	// Aging
	output logic [7:0] age_period,
	output logic age_period_tick,
	// Status outputs
	output logic lookup_engine_summary,
	output logic lookup_engine_event_pending
);

	// Elaboration checks; the logic has no meaning outside these ranges
	if (CYCLES_PER_SECOND < 1) begin : g_chk_cps
		$error("CYCLES_PER_SECOND must be at least one");
	end
	if (NUM_PORTS < 1) begin : g_chk_ports
		$error("NUM_PORTS must be at least one");
	end
	if (HOST_PORT < 0 || HOST_PORT >= NUM_PORTS) begin : g_chk_host
		$error("HOST_PORT must name one of the ports");
	end
	if (PRIO_W < 1) begin : g_chk_prio
		$error("PRIO_W must be at least one");
	end

	localparam int SEC_W = $clog2(CYCLES_PER_SECOND + 1);

	function automatic logic idx_hit(input logic [11:0] a,
		input logic [9:0] idx);
		idx_hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// Bus decode
	wire logic setup = psel && !penable;
	wire logic wr_acc = psel && penable && pwrite && pstrb[0];
	wire logic [7:0] wbyte = pwdata[7:0];
	wire logic sel_trig = idx_hit(paddr, `LEC_IDX_FLUSH_TRIG);
	wire logic sel_ctl = idx_hit(paddr, `LEC_IDX_CTL_B);
	wire logic sel_age = idx_hit(paddr, `LEC_IDX_AGE);
	wire logic sel_st = idx_hit(paddr, `LEC_IDX_STATUS);
	wire logic sel_mask = idx_hit(paddr, `LEC_IDX_MASK);
	wire logic mapped = sel_trig || sel_ctl || sel_age || sel_st || sel_mask;
	wire logic wr_trig = wr_acc && sel_trig;
	wire logic wr_ctl = wr_acc && sel_ctl;
	wire logic wr_age = wr_acc && sel_age;
	wire logic wr_st = wr_acc && sel_st;
	wire logic wr_mask = wr_acc && sel_mask;

	// Registers
	logic [7:0] ctl_q;
	logic [7:0] age_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic [1:0] trig_q;
	logic [31:0] rdata_q;
	logic err_q;
	logic [SEC_W-1:0] sec_cnt_q;
	logic [7:0] sec_in_period_q;
	logic tick_q;
	lec_pkg::lec_flush_state_type fl_state_q;
	lec_pkg::lec_flush_state_type fl_state_d;

	wire logic [1:0] scope = ctl_q[`LEC_CTL_SCOPE_HI:`LEC_CTL_SCOPE_LO];
	wire logic scope_none = (scope == lec_pkg::LEC_SCOPE_NONE);

	// Control fields as named wires for the datapath
	wire logic mc_trap_en = ctl_q[`LEC_CTL_MC_TRAP];
	wire logic dyn_filter_en = ctl_q[`LEC_CTL_DYN_EVF];
	wire logic sta_filter_en = ctl_q[`LEC_CTL_STA_EVF];
	wire lec_pkg::lec_prio_sel_type prio_sel = lec_pkg::lec_prio_sel_type'(
		ctl_q[`LEC_CTL_PRIO_HI:`LEC_CTL_PRIO_LO]);

	// Table events
	wire logic [2:0] evt;
	assign evt[`LEC_ST_LEARN_FAIL] = learn_attempt &&
		bucket_all_static;
	assign evt[`LEC_ST_ALMOST_FULL] = static_write &&
		(bucket_fill == 3'h2 || bucket_fill == 3'h3);
	assign evt[`LEC_ST_WRITE_FAIL] = static_write &&
		(bucket_fill >= 3'h4);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_status
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					status_q[gi] <= 1'b0;
				else if (evt[gi])
					status_q[gi] <= 1'b1;
				else if (wr_st && wbyte[gi])
					status_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// Flush sequencing; a trigger with no scope is ignored and starts no flush
	wire logic wr_table = wr_trig && wbyte[`LEC_TRIG_TABLE];
	wire logic wr_mstp = wr_trig && wbyte[`LEC_TRIG_MSTP];
	wire logic fl_idle = (fl_state_q == lec_pkg::LEC_FL_IDLE);
	wire logic fl_start = fl_idle && (wr_table || wr_mstp) &&
		!scope_none;
	wire logic fl_end = !fl_idle && flush_done;

	always_comb begin
		case (fl_state_q)
			lec_pkg::LEC_FL_IDLE:
				fl_state_d = fl_start ? lec_pkg::LEC_FL_BUSY : fl_state_q;
			lec_pkg::LEC_FL_BUSY:
				fl_state_d = flush_done ? lec_pkg::LEC_FL_IDLE : fl_state_q;
			default: fl_state_d = lec_pkg::LEC_FL_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fl_state_q <= lec_pkg::LEC_FL_IDLE;
		else
			fl_state_q <= fl_state_d;
	end

	// Trigger bits read one while their flush runs, then clear themselves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trig_q <= 2'h0;
		else if (fl_start)
			trig_q <= {wr_table, wr_mstp};
		else if (fl_end)
			trig_q <= 2'h0;
	end

	// Control B; scope returns to 00 when the flush is done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_q <= `LEC_RST_CTL_B;
		else if (wr_ctl)
			ctl_q <= wbyte;
		else if (fl_end)
			ctl_q[`LEC_CTL_SCOPE_HI:`LEC_CTL_SCOPE_LO] <=
				lec_pkg::LEC_SCOPE_NONE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_q <= `LEC_RST_AGE;
		else if (wr_age)
			age_q <= wbyte;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= `LEC_RST_MASK;
		else if (wr_mask)
			mask_q <= wbyte[2:0];
	end

	// Aging: one tick per age period; the datapath steps age counts on it
	wire logic sec_wrap = (sec_cnt_q == SEC_W'(CYCLES_PER_SECOND - 1));
	wire logic period_wrap = sec_wrap && (age_q != 8'h00) &&
		(sec_in_period_q >= age_q - 8'h01);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sec_cnt_q <= '0;
		else
			sec_cnt_q <= sec_wrap ? '0 : sec_cnt_q + SEC_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_in_period_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			if (period_wrap)
				sec_in_period_q <= 8'h00;
			else if (sec_wrap)
				sec_in_period_q <= sec_in_period_q + 8'h01;
			tick_q <= period_wrap;
		end
	end

	// Read data captured in setup, so every access answers in one phase
	wire logic [31:0] rd_trig = {26'h0, trig_q, 4'h0};
	wire logic [31:0] rd_ctl = {24'h0, ctl_q};
	wire logic [31:0] rd_age = {24'h0, age_q};
	wire logic [31:0] rd_st = {29'h0, status_q};
	wire logic [31:0] rd_mask = {29'h0, mask_q};
	wire logic [31:0] rd_mux = sel_trig ? rd_trig :
		sel_ctl ? rd_ctl :
		sel_age ? rd_age :
		sel_st ? rd_st :
		sel_mask ? rd_mask : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0;
			err_q <= 1'b0;
		end else if (setup) begin
			rdata_q <= pwrite ? 32'h0 : rd_mux;
			err_q <= !mapped;
		end
	end

	assign prdata = rdata_q;
	assign pready = psel && penable;
	assign pslverr = psel && penable && err_q;

	// Datapath results
	lec_fwd_resolve #(
		.NUM_PORTS(NUM_PORTS),
		.HOST_PORT(HOST_PORT),
		.PRIO_W(PRIO_W)
	) u_resolve (
		.pclk(pclk),
		.presetn(presetn),
		.mc_trap(mc_trap_en),
		.dyn_filter(dyn_filter_en),
		.sta_filter(sta_filter_en),
		.prio_sel(prio_sel),
		.lookup_valid(lookup_valid),
		.hit_dynamic(hit_dynamic),
		.hit_static(hit_static),
		.reserved_mcast(reserved_mcast),
		.double_tag_mode(double_tag_mode),
		.table_port_map(table_port_map),
		.vlan_port_map(vlan_port_map),
		.da_prio(da_prio),
		.sa_prio(sa_prio),
		.fwd_valid_q(fwd_valid),
		.fwd_port_map_q(fwd_port_map),
		.address_based_priority_q(address_based_priority)
	);

	assign flush_table_start = fl_start && wr_table;
	assign flush_mstp_start = fl_start && wr_mstp;
	assign flush_scope = scope;
	assign age_period = age_q;
	assign age_period_tick = tick_q;
	assign lookup_engine_summary = |status_q;
	// Mask gates only the pending output; status still latches
	assign lookup_engine_event_pending = |(status_q & ~mask_q);

endmodule

// *** verification/lec_ctrl_status_props.sv ***
// Checker for the lookup engine control block ports
`timescale 1ns/1ps
module lec_ctrl_status_props #(
	parameter int NUM_PORTS = 7,
	parameter int HOST_PORT = 6,
	parameter int PRIO_W = 3
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	// Lookup
	input wire logic lookup_valid,
	input wire logic [NUM_PORTS-1:0] table_port_map,
	input wire logic [PRIO_W-1:0] da_prio,
	input wire logic [PRIO_W-1:0] sa_prio,
	input wire logic fwd_valid,
	input wire logic [NUM_PORTS-1:0] fwd_port_map,
	input wire logic [PRIO_W-1:0] address_based_priority,
	// Events and flush
	input wire logic learn_attempt,
	input wire logic bucket_all_static,
	input wire logic static_write,
	input wire logic [2:0] bucket_fill,
	input wire logic flush_table_start,
	input wire logic flush_mstp_start,
	input wire logic [1:0] flush_scope,
	input wire logic lookup_engine_summary,
	input wire logic lookup_engine_event_pending
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_apb_write;
		psel && penable && pwrite;
	endsequence
	wire logic [NUM_PORTS-1:0] host_only = NUM_PORTS'(1 << HOST_PORT);
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready late");
	a_fwd_one_cycle: assert property (fwd_valid == $past(lookup_valid))
		else $error("fwd_valid timing");
	a_map_within_table: assert property (
		fwd_valid && fwd_port_map != host_only |->
		(fwd_port_map & ~$past(table_port_map)) == '0)
		else $error("port map outside table map");
	a_prio_source: assert property (fwd_valid |->
		address_based_priority == $past(da_prio) ||
		address_based_priority == $past(sa_prio))
		else $error("priority from no lookup");
	a_learn_fail: assert property (learn_attempt &&
		bucket_all_static |=> lookup_engine_summary)
		else $error("learn fail lost");
	a_almost_full: assert property (static_write &&
		bucket_fill inside {3'h2, 3'h3} |=> lookup_engine_summary)
		else $error("almost full lost");
	a_write_fail: assert property (static_write &&
		bucket_fill >= 3'h4 |=> lookup_engine_summary)
		else $error("write fail lost");
	a_status_latch: assert property (lookup_engine_summary &&
		!(psel && penable && pwrite) |=> lookup_engine_summary)
		else $error("status dropped");
	a_pending_masked: assert property (
		lookup_engine_event_pending |-> lookup_engine_summary)
		else $error("pending without status");
	a_flush_start: assert property (
		flush_table_start || flush_mstp_start |->
		s_apb_write ##0 flush_scope != 2'h0)
		else $error("flush start unqualified");
endmodule
bind lec_ctrl_status lec_ctrl_status_props #(.NUM_PORTS(NUM_PORTS),
	.HOST_PORT(HOST_PORT), .PRIO_W(PRIO_W)) u_props (.pclk, .presetn,
	.psel, .penable, .pwrite, .pready, .lookup_valid, .table_port_map,
	.da_prio, .sa_prio, .fwd_valid, .fwd_port_map, .address_based_priority,
	.learn_attempt, .bucket_all_static, .static_write, .bucket_fill,
	.flush_table_start, .flush_mstp_start, .flush_scope,
	.lookup_engine_summary, .lookup_engine_event_pending);

// *** verification/lec_flush_model.sv ***
// Flush engine model answering each flush start after a delay
`timescale 1ns/1ps
module lec_flush_model #(
	parameter int DELAY = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Flush engine side
	input wire logic flush_table_start,
	input wire logic flush_mstp_start,
	output logic flush_done,
	output int starts
);
	int cnt;
	// Slow answer so busy readback is visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			flush_done <= 1'b0;
			starts <= 0;
		end else begin
			flush_done <= (cnt == 1);
			if (flush_table_start || flush_mstp_start) begin
				cnt <= DELAY;
				starts <= starts + 1;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// *** verification/testbench.sv ***
// Self-checking testbench for the lookup engine control block
`timescale 1ns/1ps
`include "lec_defines.svh"
module testbench;
	localparam int CPS = 4;
	localparam logic [11:0] A_TRIG = {`LEC_IDX_FLUSH_TRIG, 2'b00};
	localparam logic [11:0] A_CTL = {`LEC_IDX_CTL_B, 2'b00};
	localparam logic [11:0] A_AGE = {`LEC_IDX_AGE, 2'b00};
	localparam logic [11:0] A_ST = {`LEC_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_MASK = {`LEC_IDX_MASK, 2'b00};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, lookup_valid = 1'b0, hit_dynamic = 1'b0;
	logic hit_static = 1'b0, reserved_mcast = 1'b0, double_tag_mode = 1'b0;
	logic learn_attempt = 1'b0, bucket_all_static = 1'b0;
	logic static_write = 1'b0, err, pready, pslverr, fwd_valid, flush_done;
	logic flush_table_start, flush_mstp_start, age_period_tick;
	logic lookup_engine_summary, lookup_engine_event_pending;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] bucket_fill = 3'h0, da_prio = 3'h0, sa_prio = 3'h0, abp;
	logic [6:0] table_port_map = 7'h00, vlan_port_map = 7'h00, fwd_port_map;
	logic [1:0] flush_scope;
	logic [7:0] age_period;
	int fail_count = 0, checks = 0, starts, gap;
	lec_ctrl_status #(.CYCLES_PER_SECOND(CPS)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lookup_valid(lookup_valid),
		.hit_dynamic(hit_dynamic), .hit_static(hit_static),
		.reserved_mcast(reserved_mcast), .double_tag_mode(double_tag_mode),
		.table_port_map(table_port_map), .vlan_port_map(vlan_port_map),
		.da_prio(da_prio), .sa_prio(sa_prio), .fwd_valid(fwd_valid),
		.fwd_port_map(fwd_port_map), .address_based_priority(abp),
		.learn_attempt(learn_attempt), .bucket_all_static(bucket_all_static),
		.static_write(static_write), .bucket_fill(bucket_fill),
		.flush_table_start(flush_table_start),
		.flush_mstp_start(flush_mstp_start), .flush_scope(flush_scope),
		.flush_done(flush_done), .age_period(age_period),
		.age_period_tick(age_period_tick),
		.lookup_engine_summary(lookup_engine_summary),
		.lookup_engine_event_pending(lookup_engine_event_pending));
	lec_flush_model u_flush (.pclk(pclk), .presetn(presetn),
		.flush_table_start(flush_table_start),
		.flush_mstp_start(flush_mstp_start), .flush_done(flush_done),
		.starts(starts));
	task automatic cmp(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the access edge's register updates settle before callers look
		#1;
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input int e);
		apb(1'b0, a, 0);
		cmp(n, e, rd);
	endtask
	task automatic look(input logic dy, rm, dt, input logic [2:0] da, sa);
		@(posedge pclk);
		lookup_valid <= 1'b1;
		hit_dynamic <= dy;
		hit_static <= !dy;
		reserved_mcast <= rm;
		double_tag_mode <= dt;
		table_port_map <= 7'h3c;
		vlan_port_map <= 7'h1b;
		da_prio <= da;
		sa_prio <= sa;
		@(posedge pclk);
		lookup_valid <= 1'b0;
		#1;
		cmp("fwd_valid", 1, fwd_valid);
	endtask
	task automatic ev(input logic la, as, sw, input logic [2:0] f);
		@(posedge pclk);
		learn_attempt <= la;
		bucket_all_static <= as;
		static_write <= sw;
		bucket_fill <= f;
		@(posedge pclk);
		learn_attempt <= 1'b0;
		static_write <= 1'b0;
		#1;
	endtask
	task automatic t_reset;
		rchk("ctl", A_CTL, 8'h00);
		rchk("age", A_AGE, 8'h4b);
		rchk("status", A_ST, 8'h00);
		rchk("mask", A_MASK, 8'h07);
		rchk("unmapped", 12'h000, 0);
		cmp("pslverr", 1, err);
		$display("test reset done");
	endtask
	task automatic t_fwd;
		logic [7:0] c[7] = '{8'h00, 8'h20, 8'h20, 8'h10, 8'h30, 8'h70,
			8'h70};
		logic [6:0] e[7] = '{7'h3c, 7'h18, 7'h3c, 7'h18, 7'h18, 7'h40,
			7'h18};
		logic [6:0] dy = 7'b1110011, rm = 7'b1110000, dt = 7'b0111111;
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, A_CTL, c[i]);
			look(dy[i], rm[i], dt[i], 3'h1, 3'h1);
			cmp("port_map", e[i], fwd_port_map);
		end
		$display("test forwarding done");
	endtask
	task automatic t_prio;
		logic [2:0] e1[4] = '{3'h5, 3'h2, 3'h5, 3'h2};
		logic [2:0] e2[4] = '{3'h1, 3'h6, 3'h6, 3'h1};
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, A_CTL, s);
			look(1'b1, 1'b0, 1'b1, 3'h5, 3'h2);
			cmp("prio", e1[s], abp);
			look(1'b1, 1'b0, 1'b1, 3'h1, 3'h6);
			cmp("prio", e2[s], abp);
		end
		$display("test priority done");
	endtask
	task automatic t_events;
		logic [7:0] e[5] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h01};
		apb(1'b1, A_MASK, 8'h05);
		ev(1'b1, 1'b0, 1'b0, 3'h0);
		rchk("status", A_ST, 8'h00);
		ev(1'b1, 1'b1, 1'b0, 3'h0);
		cmp("summary", 1, lookup_engine_summary);
		cmp("pending", 0, lookup_engine_event_pending);
		apb(1'b1, A_ST, 8'h00);
		rchk("status", A_ST, 8'h04);
		apb(1'b1, A_ST, 8'h04);
		cmp("summary", 0, lookup_engine_summary);
		for (int f = 0; f < 5; f++) begin
			ev(1'b0, 1'b0, 1'b1, 3'(f));
			cmp("pending", e[f][1], lookup_engine_event_pending);
			rchk("status", A_ST, e[f]);
			apb(1'b1, A_ST, 8'h07);
		end
		// Almost-full event lands on the access edge of a clear-all write
		fork
			apb(1'b1, A_ST, 8'h07);
			begin
				repeat (2) @(posedge pclk);
				static_write <= 1'b1;
				bucket_fill <= 3'h2;
				@(posedge pclk);
				static_write <= 1'b0;
			end
		join
		rchk("status", A_ST, 8'h02);
		apb(1'b1, A_ST, 8'h07);
		$display("test events done");
	endtask
	task automatic t_flush;
		apb(1'b1, A_TRIG, 8'h20);
		rchk("trig", A_TRIG, 8'h00);
		cmp("starts", 0, starts);
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, A_CTL, s << 2);
			cmp("scope", s, flush_scope);
			apb(1'b1, A_TRIG, s == 2 ? 8'h10 : 8'h20);
			cmp("starts", s, starts);
			rchk("trig", A_TRIG, s == 2 ? 8'h10 : 8'h20);
			for (int n = 0; n < 50 && flush_scope !== 2'h0; n++)
				@(posedge pclk);
			rchk("ctl", A_CTL, 8'h00);
			rchk("trig", A_TRIG, 8'h00);
		end
		$display("test flush done");
	endtask
	task automatic tick_gap;
		gap = 0;
		@(posedge pclk);
		while (age_period_tick !== 1'b1 && gap < 1000) begin
			@(posedge pclk);
			gap++;
		end
	endtask
	task automatic t_age;
		apb(1'b1, A_AGE, 8'h02);
		cmp("age_period", 8'h02, age_period);
		repeat (3) tick_gap();
		cmp("tick_gap", 2 * CPS - 1, gap);
		$display("test aging done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial forever #10 pclk = ~pclk;
	initial begin
		#400us;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fwd();
		t_prio();
		t_events();
		t_flush();
		t_age();
		complete_run();
	end
endmodule
